// ### inc/lcdsa_cfg.svh
`ifndef LCDSA_CFG_SVH
`define LCDSA_CFG_SVH

// register indices; byte address on the bus is four times the index
`define LCDSA_IDX_S1_LO      6'h0C
`define LCDSA_IDX_S1_HI      6'h0D
`define LCDSA_IDX_S2_LO      6'h0E
`define LCDSA_IDX_S2_HI      6'h0F
`define LCDSA_IDX_S1_OVF     6'h10
`define LCDSA_IDX_OFFSET     6'h11
`define LCDSA_IDX_HGT_LO     6'h12
`define LCDSA_IDX_HGT_HI     6'h13
`define LCDSA_IDX_LUT_PTR    6'h15
`define LCDSA_IDX_LUT_DATA   6'h17
`define LCDSA_IDX_ROT_CTL    6'h1B
`define LCDSA_IDX_ROT_BYTES  6'h1C
`define LCDSA_IDX_PANEL_LO   6'h20
`define LCDSA_IDX_PANEL_HI   6'h21
`define LCDSA_IDX_LINE_WORDS 6'h22

// field positions
`define LCDSA_ROT_EN_BIT     7
`define LCDSA_OVF_BIT        0
`define LCDSA_LUT_MSB        7
`define LCDSA_LUT_LSB        4

// reset values
`define LCDSA_HGT_RST        10'h3FF
`define LCDSA_PANEL_RST      10'h0F0
`define LCDSA_WORDS_RST      8'h50

// bus encodings
`define LCDSA_ADDR_W         8
`define LCDSA_RESP_OK        2'h0
`define LCDSA_RESP_SLVERR    2'h2

`endif

// ### inc/lcdsa_pkg.sv
package lcdsa_pkg;
`include "lcdsa_cfg.svh"

	typedef enum logic [1:0] {LUT_RED, LUT_GREEN, LUT_BLUE} lcdsa_phase_t;

	typedef struct packed {
		logic                       awvalid;
		logic [`LCDSA_ADDR_W-1:0]   awaddr;
		logic                       wvalid;
		logic [31:0]                wdata;
		logic [3:0]                 wstrb;
		logic                       bready;
		logic                       arvalid;
		logic [`LCDSA_ADDR_W-1:0]   araddr;
		logic                       rready;
	} lcdsa_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} lcdsa_axi_rsp_t;

	typedef struct packed {
		logic [16:0] addr;
		logic [9:0]  line;
		logic        screen2;
		logic        rotated;
	} lcdsa_line_t;

	localparam lcdsa_axi_rsp_t LCDSA_RSP_RST = '{awready: 1'b1,
		wready: 1'b1, arready: 1'b1, default: '0};

endpackage : lcdsa_pkg

// ### core/lcdsa_lut_mem.sv
`timescale 1ns/100ps
module lcdsa_lut_mem (
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        ce,
	input  wire logic        wrEn,
	input  wire logic [7:0]  wrAddr,
	input  wire logic [11:0] wrData,
	input  wire logic [7:0]  rdAddr,
	output logic      [11:0] rdData
);
	logic [11:0] mem [0:255];
	logic [11:0] next_rdData;

	always_comb begin
		next_rdData = mem[rdAddr];
	end

	// storage has no reset; software loads the palette before use
	always_ff @(posedge core_clk) begin
		if (ce && wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rdData <= 12'h000;
		end else if (ce) begin
			rdData <= next_rdData;
		end
	end
endmodule : lcdsa_lut_mem

// ### core/lcdsa_axil_slave.sv
`timescale 1ns/100ps
`include "lcdsa_cfg.svh"
module lcdsa_axil_slave (
	input  wire logic                      core_clk,
	input  wire logic                      nrst,
	input  wire logic                      ce,
	input  wire lcdsa_pkg::lcdsa_axi_req_t axiReq,
	output lcdsa_pkg::lcdsa_axi_rsp_t      axiRsp,
	output logic                           wrReq,
	output logic [5:0]                     wrIdx,
	output logic [31:0]                    wrData,
	output logic [3:0]                     wrStrb,
	input  wire logic                      wrErr,
	output logic                           rdReq,
	output logic [5:0]                     rdIdx,
	input  wire logic [31:0]               rdData,
	input  wire logic                      rdErr
);
	lcdsa_pkg::lcdsa_axi_rsp_t rsp, next_rsp;
	logic        awHeld, next_awHeld, wHeld, next_wHeld;
	logic        arHeld, next_arHeld;
	logic [7:0]  awAddr, next_awAddr, arAddr, next_arAddr;
	logic [31:0] wData, next_wData;
	logic [3:0]  wStrb, next_wStrb;

	assign axiRsp = rsp;
	assign wrReq  = ce & awHeld & wHeld & ~rsp.bvalid;
	assign rdReq  = ce & arHeld & ~rsp.rvalid;
	assign wrIdx  = awAddr[7:2];
	assign rdIdx  = arAddr[7:2];
	assign wrData = wData;
	assign wrStrb = wStrb;

	always_comb begin
		next_rsp    = rsp;
		next_awHeld = awHeld;
		next_wHeld  = wHeld;
		next_arHeld = arHeld;
		next_awAddr = awAddr;
		next_arAddr = arAddr;
		next_wData  = wData;
		next_wStrb  = wStrb;
		// address and data are taken independently, in either order
		if (axiReq.awvalid && rsp.awready) begin
			next_awHeld     = 1'b1;
			next_awAddr     = axiReq.awaddr;
			next_rsp.awready = 1'b0;
		end
		if (axiReq.wvalid && rsp.wready) begin
			next_wHeld      = 1'b1;
			next_wData      = axiReq.wdata;
			next_wStrb      = axiReq.wstrb;
			next_rsp.wready = 1'b0;
		end
		if (wrReq) begin
			next_awHeld    = 1'b0;
			next_wHeld     = 1'b0;
			next_rsp.bvalid = 1'b1;
			next_rsp.bresp = wrErr ? `LCDSA_RESP_SLVERR : `LCDSA_RESP_OK;
		end
		if (rsp.bvalid && axiReq.bready) begin
			next_rsp.bvalid  = 1'b0;
			next_rsp.awready = 1'b1;
			next_rsp.wready  = 1'b1;
		end
		if (axiReq.arvalid && rsp.arready) begin
			next_arHeld      = 1'b1;
			next_arAddr      = axiReq.araddr;
			next_rsp.arready = 1'b0;
		end
		if (rdReq) begin
			next_arHeld    = 1'b0;
			next_rsp.rvalid = 1'b1;
			next_rsp.rdata = rdData;
			next_rsp.rresp = rdErr ? `LCDSA_RESP_SLVERR : `LCDSA_RESP_OK;
		end
		if (rsp.rvalid && axiReq.rready) begin
			next_rsp.rvalid  = 1'b0;
			next_rsp.arready = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rsp    <= lcdsa_pkg::LCDSA_RSP_RST;
			awHeld <= 1'b0;
			wHeld  <= 1'b0;
			arHeld <= 1'b0;
			awAddr <= 8'h00;
			arAddr <= 8'h00;
			wData  <= 32'h0000_0000;
			wStrb  <= 4'h0;
		end else if (ce) begin
			rsp    <= next_rsp;
			awHeld <= next_awHeld;
			wHeld  <= next_wHeld;
			arHeld <= next_arHeld;
			awAddr <= next_awAddr;
			arAddr <= next_arAddr;
			wData  <= next_wData;
			wStrb  <= next_wStrb;
		end
	end
endmodule : lcdsa_axil_slave

// ### core/lcdsa_top.sv
// The AXI4-Lite register port was decided locally.
`timescale 1ns/100ps
`include "lcdsa_cfg.svh"
module lcdsa_top (
	input  wire logic                      core_clk,
	input  wire logic                      nrst,
	input  wire logic                      ce,
	input  wire lcdsa_pkg::lcdsa_axi_req_t axiReq,
	output lcdsa_pkg::lcdsa_axi_rsp_t      axiRsp,
	input  wire logic                      frameStart,
	input  wire logic                      lineNext,
	output lcdsa_pkg::lcdsa_line_t         lineOut
);
	logic        wrReq, wrErr, rdReq, rdErr;
	logic [5:0]  wrIdx, rdIdx;
	logic [31:0] wrData, rdData;
	logic [3:0]  wrStrb;
	logic [7:0]  s1Lo, s1Hi, s2Lo, s2Hi, offsetWords, hgtLo;
	logic [7:0]  next_s1Lo, next_s1Hi, next_s2Lo, next_s2Hi;
	logic [7:0]  next_offsetWords, next_hgtLo;
	logic [1:0]  hgtHi, next_hgtHi;
	logic        s1Ovf, next_s1Ovf, rotEn, next_rotEn;
	logic [7:0]  rotBytes, next_rotBytes, lineWords, next_lineWords;
	logic [9:0]  panelLines, next_panelLines, heightVal;
	logic [7:0]  lutPtr, next_lutPtr;
	logic [3:0]  redHold, next_redHold, greenHold, next_greenHold;
	logic        lutWrEn;
	logic [11:0] lutWrData, lutQ;
	logic        dataWr, dataRd, splitHere;
	logic [16:0] s1Addr;
	lcdsa_pkg::lcdsa_phase_t lutPhase, next_lutPhase;
	lcdsa_pkg::lcdsa_line_t  next_lineOut;

	lcdsa_axil_slave busPort (
		.core_clk (core_clk),
		.nrst     (nrst),
		.ce       (ce),
		.axiReq   (axiReq),
		.axiRsp   (axiRsp),
		.wrReq    (wrReq),
		.wrIdx    (wrIdx),
		.wrData   (wrData),
		.wrStrb   (wrStrb),
		.wrErr    (wrErr),
		.rdReq    (rdReq),
		.rdIdx    (rdIdx),
		.rdData   (rdData),
		.rdErr    (rdErr)
	);

	lcdsa_lut_mem palette (
		.core_clk (core_clk),
		.nrst     (nrst),
		.ce       (ce),
		.wrEn     (lutWrEn),
		.wrAddr   (lutPtr),
		.wrData   (lutWrData),
		.rdAddr   (lutPtr),
		.rdData   (lutQ)
	);

	assign heightVal = {hgtHi, hgtLo};
	assign dataWr = wrReq && wrStrb[0] && wrIdx == `LCDSA_IDX_LUT_DATA;
	assign dataRd = rdReq && rdIdx == `LCDSA_IDX_LUT_DATA;
	// the three colours land together, so a half-written entry never shows
	assign lutWrData = {redHold, greenHold,
		wrData[`LCDSA_LUT_MSB:`LCDSA_LUT_LSB]};

	// register writes and palette pointer
	always_comb begin
		next_s1Lo       = s1Lo;
		next_s1Hi       = s1Hi;
		next_s2Lo       = s2Lo;
		next_s2Hi       = s2Hi;
		next_s1Ovf      = s1Ovf;
		next_offsetWords = offsetWords;
		next_hgtLo      = hgtLo;
		next_hgtHi      = hgtHi;
		next_rotEn      = rotEn;
		next_rotBytes   = rotBytes;
		next_panelLines = panelLines;
		next_lineWords  = lineWords;
		next_lutPtr     = lutPtr;
		next_lutPhase   = lutPhase;
		next_redHold    = redHold;
		next_greenHold  = greenHold;
		lutWrEn         = 1'b0;
		wrErr           = 1'b0;
		if (wrReq) begin
			case (wrIdx)
			`LCDSA_IDX_S1_LO, `LCDSA_IDX_S1_HI, `LCDSA_IDX_S2_LO,
			`LCDSA_IDX_S2_HI, `LCDSA_IDX_S1_OVF, `LCDSA_IDX_OFFSET,
			`LCDSA_IDX_HGT_LO, `LCDSA_IDX_HGT_HI, `LCDSA_IDX_LUT_PTR,
			`LCDSA_IDX_LUT_DATA, `LCDSA_IDX_ROT_CTL,
			`LCDSA_IDX_ROT_BYTES, `LCDSA_IDX_PANEL_LO,
			`LCDSA_IDX_PANEL_HI, `LCDSA_IDX_LINE_WORDS: wrErr = 1'b0;
			default: wrErr = 1'b1;
			endcase
		end
		if (wrReq && wrStrb[0]) begin
			case (wrIdx)
			`LCDSA_IDX_S1_LO: next_s1Lo = wrData[7:0];
			`LCDSA_IDX_S1_HI: next_s1Hi = wrData[7:0];
			`LCDSA_IDX_S2_LO: next_s2Lo = wrData[7:0];
			`LCDSA_IDX_S2_HI: next_s2Hi = wrData[7:0];
			`LCDSA_IDX_S1_OVF: next_s1Ovf = wrData[`LCDSA_OVF_BIT];
			`LCDSA_IDX_OFFSET: next_offsetWords = wrData[7:0];
			`LCDSA_IDX_HGT_LO: next_hgtLo = wrData[7:0];
			`LCDSA_IDX_HGT_HI: next_hgtHi = wrData[1:0];
			`LCDSA_IDX_ROT_CTL: next_rotEn = wrData[`LCDSA_ROT_EN_BIT];
			`LCDSA_IDX_ROT_BYTES: next_rotBytes = wrData[7:0];
			`LCDSA_IDX_PANEL_LO: next_panelLines[7:0] = wrData[7:0];
			`LCDSA_IDX_PANEL_HI: next_panelLines[9:8] = wrData[1:0];
			`LCDSA_IDX_LINE_WORDS: next_lineWords = wrData[7:0];
			`LCDSA_IDX_LUT_PTR: begin
				next_lutPtr   = wrData[7:0];
				next_lutPhase = lcdsa_pkg::LUT_RED;
			end
			default: next_lutPtr = lutPtr;
			endcase
		end
		// a data write and a data read in one cycle advance the phase twice
		if (dataWr) begin
			case (next_lutPhase)
			lcdsa_pkg::LUT_RED: begin
				next_redHold  = wrData[`LCDSA_LUT_MSB:`LCDSA_LUT_LSB];
				next_lutPhase = lcdsa_pkg::LUT_GREEN;
			end
			lcdsa_pkg::LUT_GREEN: begin
				next_greenHold = wrData[`LCDSA_LUT_MSB:`LCDSA_LUT_LSB];
				next_lutPhase  = lcdsa_pkg::LUT_BLUE;
			end
			default: begin
				lutWrEn       = 1'b1;
				next_lutPtr   = next_lutPtr + 8'h01;
				next_lutPhase = lcdsa_pkg::LUT_RED;
			end
			endcase
		end
		if (dataRd) begin
			case (next_lutPhase)
			lcdsa_pkg::LUT_RED: next_lutPhase = lcdsa_pkg::LUT_GREEN;
			lcdsa_pkg::LUT_GREEN: next_lutPhase = lcdsa_pkg::LUT_BLUE;
			default: begin
				next_lutPtr   = next_lutPtr + 8'h01;
				next_lutPhase = lcdsa_pkg::LUT_RED;
			end
			endcase
		end
	end

	// read mux; unused bits stay zero
	always_comb begin
		rdData = 32'h0000_0000;
		rdErr  = 1'b0;
		case (rdIdx)
		`LCDSA_IDX_S1_LO: rdData[7:0] = s1Lo;
		`LCDSA_IDX_S1_HI: rdData[7:0] = s1Hi;
		`LCDSA_IDX_S2_LO: rdData[7:0] = s2Lo;
		`LCDSA_IDX_S2_HI: rdData[7:0] = s2Hi;
		`LCDSA_IDX_S1_OVF: rdData[`LCDSA_OVF_BIT] = s1Ovf;
		`LCDSA_IDX_OFFSET: rdData[7:0] = offsetWords;
		`LCDSA_IDX_HGT_LO: rdData[7:0] = hgtLo;
		`LCDSA_IDX_HGT_HI: rdData[1:0] = hgtHi;
		`LCDSA_IDX_LUT_PTR: rdData[7:0] = lutPtr;
		`LCDSA_IDX_ROT_CTL: rdData[`LCDSA_ROT_EN_BIT] = rotEn;
		`LCDSA_IDX_ROT_BYTES: rdData[7:0] = rotBytes;
		`LCDSA_IDX_PANEL_LO: rdData[7:0] = panelLines[7:0];
		`LCDSA_IDX_PANEL_HI: rdData[1:0] = panelLines[9:8];
		`LCDSA_IDX_LINE_WORDS: rdData[7:0] = lineWords;
		`LCDSA_IDX_LUT_DATA: begin
			case (lutPhase)
			lcdsa_pkg::LUT_RED:
				rdData[`LCDSA_LUT_MSB:`LCDSA_LUT_LSB] = lutQ[11:8];
			lcdsa_pkg::LUT_GREEN:
				rdData[`LCDSA_LUT_MSB:`LCDSA_LUT_LSB] = lutQ[7:4];
			default: rdData[`LCDSA_LUT_MSB:`LCDSA_LUT_LSB] = lutQ[3:0];
			endcase
		end
		default: rdErr = 1'b1;
		endcase
	end

	// line address generation
	assign s1Addr = rotEn ? {s1Ovf, s1Hi, s1Lo} : {1'b0, s1Hi, s1Lo};
	// split never applies to a frame fetched rotated
	assign splitHere = !lineOut.rotated && lineOut.line == heightVal
		&& heightVal < panelLines;
	always_comb begin
		next_lineOut = lineOut;
		if (frameStart) begin
			// mode is latched per frame so a mid-frame write cannot tear it
			next_lineOut.addr    = s1Addr;
			next_lineOut.line    = 10'h000;
			next_lineOut.screen2 = 1'b0;
			next_lineOut.rotated = rotEn;
		end else if (lineNext) begin
			next_lineOut.line = lineOut.line + 10'h001;
			if (splitHere) begin
				next_lineOut.addr    = {1'b0, s2Hi, s2Lo};
				next_lineOut.screen2 = 1'b1;
			end else if (lineOut.rotated) begin
				next_lineOut.addr = lineOut.addr + {9'h000, rotBytes};
			end else begin
				next_lineOut.addr = lineOut.addr + {9'h000, lineWords}
					+ {9'h000, offsetWords};
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			s1Lo        <= 8'h00;
			s1Hi        <= 8'h00;
			s2Lo        <= 8'h00;
			s2Hi        <= 8'h00;
			s1Ovf       <= 1'b0;
			offsetWords <= 8'h00;
			hgtLo       <= 8'(`LCDSA_HGT_RST);
			hgtHi       <= 2'(`LCDSA_HGT_RST >> 8);
			rotEn       <= 1'b0;
			rotBytes    <= 8'h00;
			panelLines  <= `LCDSA_PANEL_RST;
			lineWords   <= `LCDSA_WORDS_RST;
			lutPtr      <= 8'h00;
			lutPhase    <= lcdsa_pkg::LUT_RED;
			redHold     <= 4'h0;
			greenHold   <= 4'h0;
			lineOut     <= '0;
		end else if (ce) begin
			s1Lo        <= next_s1Lo;
			s1Hi        <= next_s1Hi;
			s2Lo        <= next_s2Lo;
			s2Hi        <= next_s2Hi;
			s1Ovf       <= next_s1Ovf;
			offsetWords <= next_offsetWords;
			hgtLo       <= next_hgtLo;
			hgtHi       <= next_hgtHi;
			rotEn       <= next_rotEn;
			rotBytes    <= next_rotBytes;
			panelLines  <= next_panelLines;
			lineWords   <= next_lineWords;
			lutPtr      <= next_lutPtr;
			lutPhase    <= next_lutPhase;
			redHold     <= next_redHold;
			greenHold   <= next_greenHold;
			lineOut     <= next_lineOut;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);

	sequence blueStore;
		ce && dataWr && lutPhase == lcdsa_pkg::LUT_BLUE && !dataRd;
	endsequence
	sequence ptrWrite;
		ce && wrReq && wrStrb[0] && wrIdx == `LCDSA_IDX_LUT_PTR && !dataRd;
	endsequence
	sequence rotWrite;
		ce && wrReq && wrStrb[0] && wrIdx == `LCDSA_IDX_ROT_CTL;
	endsequence

	lut_wrap_a: assert property (blueStore |-> lutWrEn ##1
		(lutPhase == lcdsa_pkg::LUT_RED && lutPtr == $past(lutPtr) + 8'h01))
		else $error("palette entry not stored or pointer not advanced");
	ptr_set_a: assert property (ptrWrite |=>
		lutPhase == lcdsa_pkg::LUT_RED && lutPtr == $past(wrData[7:0]))
		else $error("pointer write did not select red entry");
	rot_select_a: assert property (ce && frameStart |=>
		lineOut.rotated == $past(rotEn))
		else $error("frame orientation does not follow enable bit");
	rot_store_a: assert property (rotWrite |=>
		rotEn == $past(wrData[`LCDSA_ROT_EN_BIT]))
		else $error("rotated enable bit not stored");
	frame_land_a: assert property (ce && frameStart && !rotEn |=>
		lineOut.addr == {1'b0, $past(s1Hi), $past(s1Lo)}
		&& lineOut.line == 10'h000)
		else $error("landscape frame start address wrong");
	frame_rot_a: assert property (ce && frameStart && rotEn |=>
		lineOut.addr[16] == $past(s1Ovf) && lineOut.rotated)
		else $error("rotated frame lost address bit 16");
	split_jump_a: assert property (ce && lineNext && !frameStart
		&& splitHere |=> lineOut.screen2
		&& lineOut.addr == {1'b0, $past(s2Hi), $past(s2Lo)})
		else $error("second screen not started after line n");
	land_step_a: assert property (ce && lineNext && !frameStart
		&& !splitHere && !lineOut.rotated |=> lineOut.addr ==
		17'($past(lineOut.addr) + $past(lineWords) + $past(offsetWords)))
		else $error("landscape line step wrong");
	rot_step_a: assert property (ce && lineNext && !frameStart
		&& lineOut.rotated |=> lineOut.addr ==
		17'($past(lineOut.addr) + $past(rotBytes)))
		else $error("rotated line step used the offset");
	rot_nosplit_a: assert property (lineOut.rotated |-> !lineOut.screen2)
		else $error("second screen used in rotated mode");
	hgt_read_a: assert property (rdReq && rdIdx == `LCDSA_IDX_HGT_HI |=>
		axiRsp.rvalid && axiRsp.rdata[31:2] == 30'h0000_0000
		&& axiRsp.rdata[1:0] == $past(hgtHi))
		else $error("height high byte reads wrong");
	freeze_a: assert property (!ce |=> $stable(lineOut))
		else $error("line state moved with clock enable low");
endmodule : lcdsa_top

// ### test/lcdsa_panel_model.sv
`timescale 1ns/100ps
// panel line timing: one frame start, then a line step every gap+1 cycles
module lcdsa_panel_model (
	input  wire logic       core_clk,
	input  wire logic       nrst,
	input  wire logic       go,
	input  wire logic [9:0] nLines,
	input  wire logic [3:0] gap,
	output logic            frameStart,
	output logic            lineNext,
	output logic            busy
);
	initial begin
		frameStart = 1'b0;
		lineNext = 1'b0;
		busy = 1'b0;
		forever begin
			@(posedge core_clk);
			if (nrst && go && !busy) begin
				busy <= 1'b1;
				frameStart <= 1'b1;
				@(posedge core_clk);
				frameStart <= 1'b0;
				repeat (gap) @(posedge core_clk);
				for (int i = 1; i < nLines; i++) begin
					// gap 0 keeps the step high: back-to-back lines
					lineNext <= 1'b1;
					@(posedge core_clk);
					if (gap != 0) begin
						lineNext <= 1'b0;
						repeat (gap) @(posedge core_clk);
					end
				end
				lineNext <= 1'b0;
				busy <= 1'b0;
			end
		end
	end
endmodule : lcdsa_panel_model

// ### test/lcd_screen_address_split_tb.sv
`timescale 1ns/100ps
`include "lcdsa_cfg.svh"
module lcd_screen_address_split_tb;
	logic                      core_clk, nrst, ce, go, busy;
	logic                      frameStart, lineNext;
	logic [9:0]                nLines;
	logic [3:0]                gap;
	logic [31:0]               seed;
	lcdsa_pkg::lcdsa_axi_req_t req;
	lcdsa_pkg::lcdsa_axi_rsp_t rsp;
	lcdsa_pkg::lcdsa_line_t    lineOut;
	int                        failures, nTests, cyc, ph, ea, el, e2, er;
	int                        mdl[64], lut[768], stg[3];
	bit                        chk;
	int ids[] = '{6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11, 6'h12, 6'h13,
		6'h15, 6'h1B, 6'h1C, 6'h20, 6'h21, 6'h22, 6'h3F};

	lcdsa_top dut (.core_clk(core_clk), .nrst(nrst), .ce(ce),
		.axiReq(req), .axiRsp(rsp), .frameStart(frameStart),
		.lineNext(lineNext), .lineOut(lineOut));
	lcdsa_panel_model panel (.core_clk(core_clk), .nrst(nrst), .go(go),
		.nLines(nLines), .gap(gap), .frameStart(frameStart),
		.lineNext(lineNext), .busy(busy));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	function automatic int msk(int i);
		case (i)
		6'h10: return 1;
		6'h13, 6'h21: return 3;
		6'h17: return 8'hF0;
		6'h1B: return 8'h80;
		6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h11, 6'h12, 6'h15, 6'h1C, 6'h20,
		6'h22: return 8'hFF;
		default: return 0;
		endcase
	endfunction : msk

	task automatic cmpw(input logic [31:0] g, e, input string m);
		nTests++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : cmpw

	task automatic cmpl(input lcdsa_pkg::lcdsa_line_t g, e);
		nTests++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t line got %h exp %h", $time, g, e);
		end
	endtask : cmpl

	task automatic axw(input int i, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		req.awvalid <= 1'b1;
		req.awaddr <= 8'(i * 4);
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= s;
		req.bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (req.awvalid && rsp.awready)
				req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready)
				req.wvalid <= 1'b0;
		end while (!rsp.bvalid);
		r = rsp.bresp;
		req.bready <= 1'b0;
		@(posedge core_clk);
	endtask : axw

	task automatic axr(input int i, output logic [31:0] d,
		output logic [1:0] r);
		req.arvalid <= 1'b1;
		req.araddr <= 8'(i * 4);
		req.rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (req.arvalid && rsp.arready)
				req.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		d = rsp.rdata;
		r = rsp.rresp;
		req.rready <= 1'b0;
		@(posedge core_clk);
	endtask : axr

	// palette data commits all three colours only on the blue access
	task automatic wr(input int i, input logic [31:0] d,
		input logic [3:0] s = 4'h1);
		logic [1:0] r;
		int m;
		m = msk(i);
		axw(i, d, s, r);
		cmpw(r, m ? `LCDSA_RESP_OK : `LCDSA_RESP_SLVERR, "bresp");
		if (m && s[0] && i == 6'h17) begin
			stg[ph] = d[7:4];
			if (ph == 2) begin
				for (int k = 0; k < 3; k++)
					lut[mdl[6'h15] * 3 + k] = stg[k];
				mdl[6'h15] = (mdl[6'h15] + 1) & 8'hFF;
			end
			ph = (ph + 1) % 3;
		end else if (m && s[0]) begin
			mdl[i] = d & m;
			if (i == 6'h15)
				ph = 0;
		end
	endtask : wr

	task automatic rdc(input int i);
		logic [1:0] r;
		logic [31:0] d, e;
		e = 32'(mdl[i]);
		if (i == 6'h17) begin
			e = 32'(lut[mdl[6'h15] * 3 + ph] << 4);
			if (ph == 2)
				mdl[6'h15] = (mdl[6'h15] + 1) & 8'hFF;
			ph = (ph + 1) % 3;
		end
		axr(i, d, r);
		cmpw(r, msk(i) ? `LCDSA_RESP_OK : `LCDSA_RESP_SLVERR, "rresp");
		cmpw(d, e, "rdata");
	endtask : rdc

	task automatic frame(input int n, input int g);
		nLines <= 10'(n);
		gap <= 4'(g);
		go <= 1'b1;
		@(posedge core_clk iff busy);
		go <= 1'b0;
		@(posedge core_clk iff !busy);
		repeat (2) @(posedge core_clk);
	endtask : frame

	task automatic finish_test;
		$display("comparisons %0d failures %0d", nTests, failures);
		if (failures == 0 && nTests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test

	// line model; lineOut seen at the edge after the step shows the update
	always @(posedge core_clk) begin
		if (chk)
			cmpl(lineOut, {17'(ea), 10'(el), e2[0], er[0]});
		chk = 1'b0;
		if (nrst && ce && (frameStart || lineNext)) begin
			chk = 1'b1;
			if (frameStart) begin
				er = mdl[6'h1B] >> 7;
				el = 0;
				e2 = 0;
				ea = mdl[6'h0D] * 256 + mdl[6'h0C] + (er ? mdl[6'h10] << 16 : 0);
			end else if (!er && el == mdl[6'h13] * 256 + mdl[6'h12] &&
				el < mdl[6'h21] * 256 + mdl[6'h20]) begin
				ea = mdl[6'h0F] * 256 + mdl[6'h0E];
				e2 = 1;
				el++;
			end else begin
				ea += er ? mdl[6'h1C] : mdl[6'h22] + mdl[6'h11];
				el++;
			end
			ea &= 17'h1FFFF;
			el &= 10'h3FF;
		end
	end

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			$display("[FAIL] %0t timeout", $time);
			finish_test;
		end
	end

	initial begin
		seed = 32'h0A61;
		req = '0;
		ce = 1'b1;
		go = 1'b0;
		nLines = 10'h0;
		gap = 4'h0;
		nrst = 1'b0;
		mdl[6'h12] = 8'hFF;
		mdl[6'h13] = 3;
		mdl[6'h20] = 8'hF0;
		mdl[6'h22] = 8'h50;
		repeat (10) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		foreach (ids[k]) rdc(ids[k]);
		foreach (ids[k]) begin
			wr(ids[k], xs());
			rdc(ids[k]);
		end
		wr(6'h11, xs(), 4'hE);
		rdc(6'h11);
		// split screen, overflow bit set but must not matter here
		wr(6'h0C, xs());
		wr(6'h0D, xs());
		wr(6'h0E, xs());
		wr(6'h0F, xs());
		wr(6'h10, 32'h1);
		wr(6'h11, xs());
		wr(6'h22, xs());
		wr(6'h1B, 32'h0);
		wr(6'h12, 32'h3);
		wr(6'h13, 32'h0);
		wr(6'h20, 32'h8);
		wr(6'h21, 32'h0);
		frame(8, 0);
		frame(8, 2);
		wr(6'h12, 32'h7);
		frame(9, 0);
		wr(6'h12, 32'h8);
		frame(9, 1);
		// clock enable dropped mid-frame: design and model skip those steps
		fork
			frame(8, 0);
			begin
				repeat (4) @(posedge core_clk);
				repeat (6) @(posedge core_clk) ce <= ~ce;
			end
		join
		wr(6'h1B, xs() | 32'h80);
		wr(6'h12, 32'hFF);
		wr(6'h13, 32'h3);
		wr(6'h1C, xs());
		frame(6, 1);
		frame(4, 0);
		wr(6'h15, 32'hFE);
		repeat (6) wr(6'h17, xs());
		wr(6'h15, 32'hFE);
		repeat (6) rdc(6'h17);
		rdc(6'h15);
		finish_test;
	end
endmodule : lcd_screen_address_split_tb
